// ### verilog/switch_config_regs.svh
// Bit positions, reset word and timing constants of the switch configuration block
`ifndef SWITCH_CONFIG_REGS_SVH
`define SWITCH_CONFIG_REGS_SVH

`define CFG_RESET_WORD        32'h00000800
`define CFG_WRITE_MASK        32'h0001FFFF
`define CFG_P2_ADMIT_GAP_BIT  16
`define CFG_P2_UNK_TO_P1_BIT  14
`define CFG_P1_UNK_TO_P2_BIT  13
`define CFG_P2_UNK_HOST_BIT   12
`define CFG_CUT_THRU_BIT      11
`define CFG_TX_RDY_EMPTY_BIT  8
`define CFG_SFD_SRC_BIT       7
`define CFG_CLR_ON_RD_BIT     6
`define CFG_CRC_APPEND_BIT    5
`define CFG_P1_ADMIT_GAP_BIT  4
`define CFG_P1_UNK_HOST_BIT   2
`define CFG_MDC_SPEED_HI      1
`define CFG_MDC_SPEED_LO      0

`define MDC_SPEED_2M5         2'h0
`define MDC_SPEED_4M166       2'h1

// Clock period and management clock periods, in ns
`define CLK_PERIOD_NS         8
`define MDC_2M5_PERIOD_NS     400
`define MDC_4M166_PERIOD_NS   240
// Half periods in cycles; both divide exactly, 25 and 15 cycles of 8 ns
`define MDC_2M5_HALF_CYC      (`MDC_2M5_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define MDC_4M166_HALF_CYC    (`MDC_4M166_PERIOD_NS / (2 * `CLK_PERIOD_NS))

`define CRC_INIT              32'hFFFFFFFF
`define CRC_POLY_REFL         32'hEDB88320
`define CRC_RESIDUE           32'hDEBB20E3
`define CRC_LAST_BYTE_IDX     2'h3

`endif

// ### verilog/switch_config_pkg.sv
// Types shared by the switch configuration block
package switch_config_pkg;

    typedef enum logic [0:0] {
        TX_PASS   = 1'b0,
        TX_APPEND = 1'b1
    } tx_state_type;

endpackage : switch_config_pkg

// ### verilog/switch_config_fields.sv
// Switch configuration word, forwarding defaults, statistics, CRC and MDC rate logic
`timescale 1ns/1ps
`default_nettype none
`include "switch_config_regs.svh"

// Function
// - Port-1 unmatched frames dropped unless bit 13 or port-1 host bit; bit 13 forwards.
// - Per-port unknown-to-host bits send unmatched frames to host, low priority queue.
// - Generic SPI: transmit-ready on frame sent, or on empty FIFO when bit 8 set.
// - Bit 7 picks timestamp delimiter detect: 0 from PHY, 1 from MAC.
// - Clear-on-read off: reads leave counters, counters wrap to zero.
// - Clear-on-read on: read clears counter, counters saturate until read.
// - Generic SPI with clear-on-read: read also clears the next counter.
// - Bit 5 set: MAC appends CRC; clear: host frame already carries CRC.
// - Check CRC32 of each host frame carrying its own CRC (bit 5 clear), flag error on mismatch.
// - Received frames reach the host with their CRC32 kept.
// - Bit 4 set: port-1 MAC admits frames violating minimum gap.
// - Bits 1:0 set MDC rate: 00 is 2.5 MHz, 01 is 4.166 MHz.
// - Frame failing transmit CRC check is still sent.
module switch_config_fields
    import switch_config_pkg::*;
#(
    parameter int NUM_CNT = 16,
    parameter int CNT_W   = 32
) (
    // Clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RST_B,
    // Configuration word access
    input  wire logic                       CFG_WR,
    input  wire logic [31:0]                CFG_WDATA,
    output var  logic [31:0]                CFG_RDATA,
    input  wire logic                       GENERIC_SPI,
    // Forwarding decision for unmatched frames
    input  wire logic                       FWD_REQ,
    input  wire logic                       FWD_FROM_P2,
    input  wire logic                       FWD_MATCH,
    output logic                            FWD_VALID,
    output logic                            FWD_TO_HOST,
    output logic                            FWD_TO_PORT,
    output logic                            FWD_DROP,
    output logic                            FWD_LOW_PRIO,
    output logic                            CUT_THRU_EN,
    // Transmit ready
    input  wire logic                       TX_FRAME_SENT,
    input  wire logic                       TX_FIFO_EMPTY,
    output logic                            TX_RDY,
    // Timestamp delimiter detect
    input  wire logic                       SFD_PHY,
    input  wire logic                       SFD_MAC,
    output logic                            SFD_TS,
    // Statistics counters
    input  wire logic [NUM_CNT-1:0]         CNT_INC,
    input  wire logic                       CNT_RD,
    input  wire logic [$clog2(NUM_CNT)-1:0] CNT_RD_IDX,
    output logic [CNT_W-1:0]                CNT_RDATA,
    // Host transmit byte stream
    input  wire logic                       TX_IN_VALID,
    input  wire logic [7:0]                 TX_IN_DATA,
    input  wire logic                       TX_IN_LAST,
    output logic                            TX_IN_READY,
    output logic                            TX_OUT_VALID,
    output logic [7:0]                      TX_OUT_DATA,
    output logic                            TX_OUT_LAST,
    output logic                            TX_FCS_ERR,
    // Receive byte stream toward host
    input  wire logic                       RX_IN_VALID,
    input  wire logic [7:0]                 RX_IN_DATA,
    input  wire logic                       RX_IN_LAST,
    output logic                            RX_OUT_VALID,
    output logic [7:0]                      RX_OUT_DATA,
    output logic                            RX_OUT_LAST,
    // Minimum gap admission
    input  wire logic                       P1_RX_START,
    input  wire logic                       P1_GAP_SHORT,
    input  wire logic                       P2_RX_START,
    input  wire logic                       P2_GAP_SHORT,
    output logic                            P1_RX_REJECT,
    output logic                            P2_RX_REJECT,
    // Management clock
    output logic                            MDC,
    output logic                            MDC_RISE
);

    if (NUM_CNT < 2 || CNT_W < 2) begin : g_bad_params
        $error("switch_config_fields: NUM_CNT and CNT_W must be at least 2");
    end

    // ----------------------------------------------------------------
    // Configuration word
    // ----------------------------------------------------------------
    logic [31:0] cfg_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_q <= `CFG_RESET_WORD;
        end else if (CFG_WR) begin
            cfg_q <= CFG_WDATA & `CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CFG_RDATA   <= `CFG_RESET_WORD;
            CUT_THRU_EN <= 1'b1;
        end else begin
            CFG_RDATA   <= cfg_q;
            CUT_THRU_EN <= cfg_q[`CFG_CUT_THRU_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Forwarding of frames matching no address filter
    // ----------------------------------------------------------------
    logic unk_to_port;
    logic unk_to_host;

    always_comb begin
        unk_to_port = FWD_FROM_P2 ? cfg_q[`CFG_P2_UNK_TO_P1_BIT] : cfg_q[`CFG_P1_UNK_TO_P2_BIT];
        unk_to_host = FWD_FROM_P2 ? cfg_q[`CFG_P2_UNK_HOST_BIT] : cfg_q[`CFG_P1_UNK_HOST_BIT];
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            FWD_VALID    <= 1'b0;
            FWD_TO_HOST  <= 1'b0;
            FWD_TO_PORT  <= 1'b0;
            FWD_DROP     <= 1'b0;
            FWD_LOW_PRIO <= 1'b0;
        end else begin
            FWD_VALID    <= FWD_REQ && !FWD_MATCH;
            FWD_TO_PORT  <= FWD_REQ && !FWD_MATCH && unk_to_port;
            FWD_TO_HOST  <= FWD_REQ && !FWD_MATCH && unk_to_host;
            FWD_LOW_PRIO <= FWD_REQ && !FWD_MATCH && unk_to_host;
            FWD_DROP     <= FWD_REQ && !FWD_MATCH && !unk_to_port && !unk_to_host;
        end
    end

    // ----------------------------------------------------------------
    // Transmit ready, delimiter source, gap admission
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TX_RDY <= 1'b0;
        end else begin
            // ready on sent frame, or on empty FIFO instead when bit 8 set
            TX_RDY <= GENERIC_SPI &&
                      (cfg_q[`CFG_TX_RDY_EMPTY_BIT] ? TX_FIFO_EMPTY : TX_FRAME_SENT);
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SFD_TS <= 1'b0;
        end else begin
            SFD_TS <= cfg_q[`CFG_SFD_SRC_BIT] ? SFD_MAC : SFD_PHY;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            P1_RX_REJECT <= 1'b0;
            P2_RX_REJECT <= 1'b0;
        end else begin
            P1_RX_REJECT <= P1_RX_START && P1_GAP_SHORT && !cfg_q[`CFG_P1_ADMIT_GAP_BIT];
            P2_RX_REJECT <= P2_RX_START && P2_GAP_SHORT && !cfg_q[`CFG_P2_ADMIT_GAP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Statistics counters
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q [NUM_CNT];
    logic             clr_on_rd;

    assign clr_on_rd = cfg_q[`CFG_CLR_ON_RD_BIT];

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        localparam int IDX_W = $clog2(NUM_CNT);
        logic hit;
        logic clr;
        // with generic SPI and clear-on-read, a read also clears the next location
        assign hit = CNT_RD && ((CNT_RD_IDX == IDX_W'(i)) ||
                     (GENERIC_SPI && i > 0 &&
                      (CNT_RD_IDX == IDX_W'(i - 1))));
        assign clr = hit && clr_on_rd;

        always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
                cnt_q[i] <= '0;
            end else if (clr) begin
                // An event in the clearing cycle is kept
                cnt_q[i] <= CNT_W'(CNT_INC[i]);
            end else if (CNT_INC[i]) begin
                if (!(clr_on_rd && &cnt_q[i]))
                    cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CNT_RDATA <= '0;
        end else if (CNT_RD) begin
            CNT_RDATA <= cnt_q[CNT_RD_IDX];
        end
    end

    // ----------------------------------------------------------------
    // Transmit CRC append and check
    // ----------------------------------------------------------------
    function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        c = crc ^ {24'h000000, b};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

    tx_state_type tx_state_q;
    logic [31:0]  crc_q;
    logic [1:0]   app_idx_q;
    logic         tx_take;
    logic [31:0]  crc_d;

    assign tx_take = TX_IN_VALID && TX_IN_READY;
    assign crc_d   = crc_byte(crc_q, TX_IN_DATA);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_state_q   <= TX_PASS;
            crc_q        <= `CRC_INIT;
            app_idx_q    <= 2'h0;
            TX_IN_READY  <= 1'b1;
            TX_OUT_VALID <= 1'b0;
            TX_OUT_DATA  <= 8'h00;
            TX_OUT_LAST  <= 1'b0;
            TX_FCS_ERR   <= 1'b0;
        end else begin
            TX_OUT_VALID <= 1'b0;
            TX_OUT_LAST  <= 1'b0;
            TX_FCS_ERR   <= 1'b0;
            unique case (tx_state_q)
                TX_PASS: begin
                    if (tx_take) begin
                        TX_OUT_VALID <= 1'b1;
                        TX_OUT_DATA  <= TX_IN_DATA;
                        crc_q        <= crc_d;
                        if (TX_IN_LAST) begin
                            if (cfg_q[`CFG_CRC_APPEND_BIT]) begin
                                tx_state_q  <= TX_APPEND;
                                app_idx_q   <= 2'h0;
                                TX_IN_READY <= 1'b0;
                            end else begin
                                // host CRC checked, frame still sent
                                TX_OUT_LAST <= 1'b1;
                                TX_FCS_ERR  <= (crc_d != `CRC_RESIDUE);
                                crc_q       <= `CRC_INIT;
                            end
                        end
                    end
                end
                TX_APPEND: begin
                    TX_OUT_VALID <= 1'b1;
                    TX_OUT_DATA  <= ~crc_q[8*app_idx_q +: 8];
                    app_idx_q    <= app_idx_q + 2'h1;
                    if (app_idx_q == `CRC_LAST_BYTE_IDX) begin
                        TX_OUT_LAST <= 1'b1;
                        crc_q       <= `CRC_INIT;
                        tx_state_q  <= TX_PASS;
                        TX_IN_READY <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receive path toward host keeps the frame check bytes
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RX_OUT_VALID <= 1'b0;
            RX_OUT_DATA  <= 8'h00;
            RX_OUT_LAST  <= 1'b0;
        end else begin
            RX_OUT_VALID <= RX_IN_VALID;
            RX_OUT_DATA  <= RX_IN_DATA;
            RX_OUT_LAST  <= RX_IN_VALID && RX_IN_LAST;
        end
    end

    // ----------------------------------------------------------------
    // Management clock divider
    // ----------------------------------------------------------------
    localparam logic [7:0] HALF_SLOW = 8'(`MDC_2M5_HALF_CYC);
    localparam logic [7:0] HALF_FAST = 8'(`MDC_4M166_HALF_CYC);

    logic [7:0] mdc_cnt_q;
    logic [7:0] mdc_half;

    // rate select; reserved codes run at the slow rate
    assign mdc_half = (cfg_q[`CFG_MDC_SPEED_HI:`CFG_MDC_SPEED_LO] == `MDC_SPEED_4M166)
                      ? HALF_FAST : HALF_SLOW;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mdc_cnt_q <= 8'h00;
            MDC       <= 1'b0;
            MDC_RISE  <= 1'b0;
        end else begin
            MDC_RISE <= 1'b0;
            if (mdc_cnt_q >= mdc_half - 8'h01) begin
                mdc_cnt_q <= 8'h00;
                MDC       <= !MDC;
                MDC_RISE  <= !MDC;
            end else begin
                mdc_cnt_q <= mdc_cnt_q + 8'h01;
            end
        end
    end

endmodule : switch_config_fields
`default_nettype wire

// ### verif/switch_config_fields_chk.sv
// Property checker for the switch configuration block
`timescale 1ns/1ps
`default_nettype none
module switch_config_fields_chk (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // Configuration
    input wire logic        CFG_WR,
    input wire logic [31:0] CFG_RDATA,
    input wire logic        GENERIC_SPI,
    input wire logic        CUT_THRU_EN,
    // Forwarding
    input wire logic        FWD_REQ,
    input wire logic        FWD_FROM_P2,
    input wire logic        FWD_MATCH,
    input wire logic        FWD_TO_HOST,
    input wire logic        FWD_TO_PORT,
    input wire logic        FWD_DROP,
    input wire logic        FWD_LOW_PRIO,
    // Status and streams
    input wire logic        TX_FRAME_SENT,
    input wire logic        TX_FIFO_EMPTY,
    input wire logic        TX_RDY,
    input wire logic        SFD_PHY,
    input wire logic        SFD_MAC,
    input wire logic        SFD_TS,
    input wire logic        TX_OUT_LAST,
    input wire logic        TX_FCS_ERR,
    input wire logic        P1_RX_START,
    input wire logic        P1_GAP_SHORT,
    input wire logic        P1_RX_REJECT,
    input wire logic        MDC,
    input wire logic        MDC_RISE
);
    logic [1:0] wr_q;
    logic       quiet;
    // Effects lag a write; judge only once the word has settled
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_q <= 2'h0;
        end else begin
            wr_q <= {wr_q[0], CFG_WR};
        end
    end
    assign quiet = !CFG_WR && (wr_q == 2'h0);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_p1_default_fwd: assert property (quiet && FWD_REQ && !FWD_MATCH && !FWD_FROM_P2 |=>
        FWD_TO_PORT == $past(CFG_RDATA[13])
        && FWD_DROP == !($past(CFG_RDATA[13]) || $past(CFG_RDATA[2])))
        else $error("port 1 default forwarding wrong");
    a_unknown_to_host: assert property (quiet && FWD_REQ && !FWD_MATCH |=>
        FWD_TO_HOST == ($past(FWD_FROM_P2) ? $past(CFG_RDATA[12]) : $past(CFG_RDATA[2]))
        && FWD_LOW_PRIO == FWD_TO_HOST)
        else $error("host forwarding wrong");
    a_cut_follows: assert property (CUT_THRU_EN == CFG_RDATA[11])
        else $error("cut-through enable differs from word");
    a_tx_rdy_source: assert property (quiet |=> TX_RDY == ($past(GENERIC_SPI)
        && ($past(CFG_RDATA[8]) ? $past(TX_FIFO_EMPTY) : $past(TX_FRAME_SENT))))
        else $error("transmit ready source wrong");
    a_sfd_source: assert property (quiet |=>
        SFD_TS == ($past(CFG_RDATA[7]) ? $past(SFD_MAC) : $past(SFD_PHY)))
        else $error("delimiter source wrong");
    a_fcs_on_last: assert property (TX_FCS_ERR |-> TX_OUT_LAST && !(quiet && CFG_RDATA[5]))
        else $error("checksum error off the last byte");
    a_gap_admit: assert property (quiet && P1_RX_START && P1_GAP_SHORT |=>
        P1_RX_REJECT == !$past(CFG_RDATA[4]))
        else $error("short gap admission wrong");
    a_mdc_rise_mark: assert property (MDC_RISE == $rose(MDC))
        else $error("clock rise mark misplaced");
    a_mdc_fast_half: assert property (quiet && $rose(MDC) && CFG_RDATA[1:0] == 2'h1 |->
        MDC[*8] ##1 MDC[*7] ##1 !MDC)
        else $error("fast management clock half period wrong");
    c_drop: cover property (FWD_DROP);
    c_fcs: cover property (TX_FCS_ERR);
    c_fast_mdc: cover property (MDC_RISE && CFG_RDATA[1:0] == 2'h1);
endmodule : switch_config_fields_chk
bind switch_config_fields switch_config_fields_chk u_chk (
    .CLK, .RST_B, .CFG_WR, .CFG_RDATA, .GENERIC_SPI, .CUT_THRU_EN, .FWD_REQ, .FWD_FROM_P2,
    .FWD_MATCH, .FWD_TO_HOST, .FWD_TO_PORT, .FWD_DROP, .FWD_LOW_PRIO, .TX_FRAME_SENT,
    .TX_FIFO_EMPTY, .TX_RDY, .SFD_PHY, .SFD_MAC, .SFD_TS, .TX_OUT_LAST, .TX_FCS_ERR,
    .P1_RX_START, .P1_GAP_SHORT, .P1_RX_REJECT, .MDC, .MDC_RISE);
`default_nettype wire

// ### verif/host_model.sv
// Host controller model: configuration writes and transmit frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       clk,
    // Configuration word
    output logic            cfg_wr,
    output logic [31:0]     cfg_wdata,
    // Transmit byte stream
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_last
);
    logic [31:0] fcs;
    initial begin
        {cfg_wr, cfg_wdata, tx_valid, tx_data, tx_last} = '0;
    end
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h0, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        end
        return r;
    endfunction : crc_step
    // cut-through bit 11 stays set in every word written
    task automatic write_cfg(input logic [31:0] w);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_wdata = w | 32'h00000800;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_wdata = ~cfg_wdata;
        repeat (2) @(negedge clk);
    endtask : write_cfg
    // frame carries its own checksum when asked; corrupt flips one bit
    task automatic send_frame(input int n, input bit with_fcs, input bit corrupt);
        logic [31:0] c;
        int          total;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n; i++) begin
            c = crc_step(c, 8'h11 + i[7:0]);
        end
        fcs = ~c ^ {31'h0, corrupt};
        total = with_fcs ? n + 4 : n;
        for (int i = 0; i < total; i++) begin
            @(negedge clk);
            while (!tx_ready) @(negedge clk);
            tx_valid = 1'b1;
            tx_data = (i < n) ? 8'h11 + i[7:0] : fcs[8*(i-n) +: 8];
            tx_last = (i == total - 1);
        end
        @(negedge clk);
        tx_valid = 1'b0;
        tx_last = 1'b0;
        tx_data = ~tx_data;
    endtask : send_frame
endmodule : host_model
`default_nettype wire

// ### verif/switch_config_fields_tb.sv
// Self-checking bench for the switch configuration block
`timescale 1ns/1ps
`default_nettype none
module switch_config_fields_tb;
    logic CLK, RST_B, CFG_WR, GENERIC_SPI, FWD_REQ, FWD_FROM_P2, FWD_MATCH, FWD_VALID;
    logic FWD_TO_HOST, FWD_TO_PORT, FWD_DROP, FWD_LOW_PRIO, CUT_THRU_EN, TX_FRAME_SENT;
    logic TX_FIFO_EMPTY, TX_RDY, SFD_PHY, SFD_MAC, SFD_TS, CNT_RD, TX_IN_VALID, TX_IN_LAST;
    logic TX_IN_READY, TX_OUT_VALID, TX_OUT_LAST, TX_FCS_ERR, RX_IN_VALID, RX_IN_LAST;
    logic RX_OUT_VALID, RX_OUT_LAST, MDC, MDC_RISE, P1_RX_START, P1_GAP_SHORT, P2_RX_START;
    logic P2_GAP_SHORT, P1_RX_REJECT, P2_RX_REJECT, fcs_seen;
    logic [31:0] CFG_WDATA, CFG_RDATA, out_tail;
    logic [7:0]  TX_IN_DATA, TX_OUT_DATA, RX_IN_DATA, RX_OUT_DATA;
    logic [15:0] CNT_INC;
    logic [3:0]  CNT_RD_IDX, CNT_RDATA;
    int          bad_count = 0;
    int          checks_done = 0;
    int          out_bytes = 0;
    int          n;
    // Narrow counters so wrap and saturation come quickly
    switch_config_fields #(.NUM_CNT(16), .CNT_W(4)) DUT (.CLK, .RST_B, .CFG_WR, .CFG_WDATA,
        .CFG_RDATA, .GENERIC_SPI, .FWD_REQ, .FWD_FROM_P2, .FWD_MATCH, .FWD_VALID, .FWD_TO_HOST,
        .FWD_TO_PORT, .FWD_DROP, .FWD_LOW_PRIO, .CUT_THRU_EN, .TX_FRAME_SENT, .TX_FIFO_EMPTY,
        .TX_RDY, .SFD_PHY, .SFD_MAC, .SFD_TS, .CNT_INC, .CNT_RD, .CNT_RD_IDX, .CNT_RDATA,
        .TX_IN_VALID, .TX_IN_DATA, .TX_IN_LAST, .TX_IN_READY, .TX_OUT_VALID, .TX_OUT_DATA,
        .TX_OUT_LAST, .TX_FCS_ERR, .RX_IN_VALID, .RX_IN_DATA, .RX_IN_LAST, .RX_OUT_VALID,
        .RX_OUT_DATA, .RX_OUT_LAST, .P1_RX_START, .P1_GAP_SHORT, .P2_RX_START, .P2_GAP_SHORT,
        .P1_RX_REJECT, .P2_RX_REJECT, .MDC, .MDC_RISE);
    host_model host (.clk(CLK), .cfg_wr(CFG_WR), .cfg_wdata(CFG_WDATA), .tx_ready(TX_IN_READY),
        .tx_valid(TX_IN_VALID), .tx_data(TX_IN_DATA), .tx_last(TX_IN_LAST));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    always @(negedge CLK) begin
        if (TX_OUT_VALID) begin
            out_bytes++;
            out_tail = {TX_OUT_DATA, out_tail[31:8]};
            fcs_seen = fcs_seen | TX_FCS_ERR;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic t_forward;
        logic [31:0] w;
        for (int k = 0; k < 8; k++) begin
            w = k[2] ? {17'h0, k[1], 1'b0, k[0], 12'h0} : {18'h0, k[1], 10'h0, k[0], 2'h0};
            host.write_cfg(w);
            FWD_REQ = 1'b1;
            FWD_FROM_P2 = k[2];
            @(negedge CLK);
            FWD_REQ = 1'b0;
            chk("valid", 1'b1, FWD_VALID);
            chk("to port", k[1], FWD_TO_PORT);
            chk("drop", !k[1] && !k[0], FWD_DROP);
            chk("to host", k[0], FWD_TO_HOST);
            chk("low prio", k[0], FWD_LOW_PRIO);
        end
        $display("forwarding test done");
    endtask : t_forward
    task automatic t_status;
        {GENERIC_SPI, TX_FRAME_SENT, SFD_PHY} = 3'h7;
        for (int k = 0; k < 2; k++) begin
            host.write_cfg(k[0] ? 32'h00000180 : 32'h0);
            chk("tx ready", !k[0], TX_RDY);
            chk("delimiter", !k[0], SFD_TS);
        end
        GENERIC_SPI = 1'b0;
        repeat (2) @(negedge CLK);
        chk("tx ready off", 1'b0, TX_RDY);
        $display("status test done");
    endtask : t_status
    task automatic bump(input int idx, input int cnt);
        CNT_INC[idx] = 1'b1;
        repeat (cnt) @(negedge CLK);
        CNT_INC[idx] = 1'b0;
        @(negedge CLK);
    endtask : bump
    task automatic rd(input logic [3:0] idx, input logic [3:0] exp);
        CNT_RD = 1'b1;
        CNT_RD_IDX = idx;
        @(negedge CLK);
        CNT_RD = 1'b0;
        chk("counter", exp, CNT_RDATA);
        @(negedge CLK);
    endtask : rd
    task automatic t_counters;
        GENERIC_SPI = 1'b1;
        host.write_cfg(32'h0);
        bump(3, 18);
        rd(4'h3, 4'h2);
        rd(4'h3, 4'h2);
        host.write_cfg(32'h00000040);
        bump(5, 20);
        bump(6, 2);
        rd(4'h5, 4'hF);
        rd(4'h6, 4'h0);
        rd(4'h5, 4'h0);
        $display("counter test done");
    endtask : t_counters
    task automatic frame(input logic [31:0] cfg, input bit with_fcs, input bit bad);
        host.write_cfg(cfg);
        out_bytes = 0;
        fcs_seen = 1'b0;
        host.send_frame(6, with_fcs, bad);
        for (int i = 0; i < 20 && out_bytes < 10; i++) @(negedge CLK);
    endtask : frame
    task automatic t_tx;
        frame(32'h0, 1'b1, 1'b1);
        chk("bad frame bytes", 10, out_bytes);
        chk("fcs error", 1'b1, fcs_seen);
        frame(32'h0, 1'b1, 1'b0);
        chk("fcs clean", 1'b0, fcs_seen);
        frame(32'h00000020, 1'b0, 1'b0);
        chk("appended bytes", 10, out_bytes);
        chk("appended crc", host.fcs, out_tail);
        $display("transmit test done");
    endtask : t_tx
    task automatic t_misc;
        for (int k = 0; k < 2; k++) begin
            host.write_cfg(k[0] ? 32'h00010010 : 32'h0);
            {P1_RX_START, P1_GAP_SHORT, P2_RX_START, P2_GAP_SHORT} = 4'hF;
            @(negedge CLK);
            {P1_RX_START, P2_RX_START} = 2'h0;
            chk("gap reject", !k[0], P1_RX_REJECT);
            chk("gap reject p2", !k[0], P2_RX_REJECT);
        end
        {RX_IN_VALID, RX_IN_DATA, RX_IN_LAST} = {1'b1, 8'hC3, 1'b1};
        @(negedge CLK);
        {RX_IN_VALID, RX_IN_DATA, RX_IN_LAST} = {1'b0, 8'h3C, 1'b0};
        chk("rx byte", {1'b1, 8'hC3, 1'b1}, {RX_OUT_VALID, RX_OUT_DATA, RX_OUT_LAST});
        for (int k = 0; k < 2; k++) begin
            host.write_cfg(k);
            repeat (2) begin
                n = 0;
                for (int i = 0; i < 200 && !MDC_RISE; i++) @(negedge CLK);
                while (MDC && n < 100) begin
                    n++;
                    @(negedge CLK);
                end
            end
            chk("mdc half period", k[0] ? 15 : 25, n);
        end
        $display("gap, receive and clock test done");
    endtask : t_misc
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        {GENERIC_SPI, FWD_REQ, FWD_FROM_P2, FWD_MATCH, TX_FRAME_SENT, TX_FIFO_EMPTY} = '0;
        {SFD_PHY, SFD_MAC, CNT_INC, CNT_RD, CNT_RD_IDX, RX_IN_VALID, RX_IN_DATA} = '0;
        {RX_IN_LAST, P1_RX_START, P1_GAP_SHORT, P2_RX_START, P2_GAP_SHORT, fcs_seen} = '0;
        RST_B = 1'b0;
        repeat (16) @(negedge CLK);
        RST_B = 1'b1;
        chk("reset word", 32'h00000800, CFG_RDATA);
        chk("cut-through", 1'b1, CUT_THRU_EN);
        host.write_cfg(32'hFFFFFFFF);
        chk("written word", 32'h0001FFFF, CFG_RDATA);
        t_forward();
        t_status();
        t_counters();
        t_tx();
        t_misc();
        stop_test();
    end
    // Whole run needs a few hundred cycles
    initial begin
        #100000;
        bad_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : switch_config_fields_tb
`default_nettype wire
